// File: rtl/sram_boundary_scan_tap.sv
// tap controller, instruction decode and scan chains of the memory part
// assumes tck from the external tester; pins arrive on clk_sys
// Operation
// R1 - state machine steps on tms each tck rise
// R2 - code 000 captures ring, boundary chain selected
// R3 - code 001 loads and shifts identification word
// R4 - identification never disturbs memory operation
// R5 - code 010 samples, floats memory outputs
// R6 - tester never loads codes 011, 101, 110
// R7 - code 100 samples pins, memory undisturbed
// R8 - id bits 31:29 version, 28:12 part
// R9 - id bits 11:1 maker code
// R10 - id bit 0 always one
// R11 - code 111 selects one-bit bypass
// R12 - tdi sampled rising, tdo driven falling
// R13 - capture-ir loads 01 into low bits
// R14 - reset state loads identification instruction
// R15 - 107-cell chain, sixteen-state controller
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap
    import tap_pkg::*;
(
    // system side
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [tap_pkg::PIN_W-1:0] pin_state,
    // test port
    input  wire logic                      tck,
    input  wire logic                      tms,
    input  wire logic                      tdi,
    output logic                           tdo,
    output logic                           tdo_oe,
    // pin control back to the memory
    output logic [tap_pkg::PIN_W-1:0]      pin_drive,
    output logic                           extest_mode,
    output logic                           out_float
);
    import tap_pkg::*;
    // ------------------------------------------------------------------
    // reset release, one copy per domain
    // ------------------------------------------------------------------
    logic [1:0] rsys_ff;   // system-side reset synchroniser
    logic [1:0] rtck_ff;   // tck-side reset synchroniser
    logic       rs_n;
    logic       rt_n;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) rsys_ff <= 2'h0;
        else        rsys_ff <= {rsys_ff[0], 1'h1};
    end
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) rtck_ff <= 2'h0;
        else        rtck_ff <= {rtck_ff[0], 1'h1};
    end
    assign rs_n = rsys_ff[1];
    assign rt_n = rtck_ff[1];
    // ------------------------------------------------------------------
    // pins are sampled on clk_sys, then crossed into tck (two stages)
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pin_s_ff;   // system-domain snapshot
    logic [PIN_W-1:0] pin_m_ff;   // first tck stage, read only by next
    logic [PIN_W-1:0] pin_t_ff;   // settled copy; slow pins only
    always_ff @(posedge clk_sys or negedge rs_n) begin
        if (!rs_n) pin_s_ff <= '0;
        else       pin_s_ff <= pin_state;
    end
    // limitation: fast-toggling pins may capture an arbitrary mix
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) begin
            pin_m_ff <= '0;
            pin_t_ff <= '0;
        end else begin
            pin_m_ff <= pin_s_ff;
            pin_t_ff <= pin_m_ff;
        end
    end
    // ------------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------------
    tap_state_t st_ff;     // controller state
    tap_state_t nxt_st;
    always_comb begin
        case (st_ff) // [R15]
            S_RESET:  nxt_st = tms ? S_RESET  : S_IDLE;
            S_IDLE:   nxt_st = tms ? S_SEL_DR : S_IDLE;
            S_SEL_DR: nxt_st = tms ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: nxt_st = tms ? S_EX1_DR : S_SH_DR;
            S_SH_DR:  nxt_st = tms ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: nxt_st = tms ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: nxt_st = tms ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: nxt_st = tms ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: nxt_st = tms ? S_SEL_DR : S_IDLE;
            S_SEL_IR: nxt_st = tms ? S_RESET  : S_CAP_IR;
            S_CAP_IR: nxt_st = tms ? S_EX1_IR : S_SH_IR;
            S_SH_IR:  nxt_st = tms ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: nxt_st = tms ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: nxt_st = tms ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: nxt_st = tms ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: nxt_st = tms ? S_SEL_DR : S_IDLE;
            default:  nxt_st = S_RESET;
        endcase
    end
    // tms is sampled straight on tck: it is the clock's own data
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) st_ff <= S_RESET;
        else       st_ff <= nxt_st; // [R1]
    end
    // ------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------
    logic [IR_W-1:0] ir_sh_ff;  // instruction shift stage
    logic [IR_W-1:0] ir_ff;     // current instruction
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) begin
            ir_sh_ff <= INS_IDCODE;
            ir_ff    <= INS_IDCODE; // [R14]
        end else begin
            case (st_ff)
                S_RESET:  ir_ff    <= INS_IDCODE; // [R14]
                S_CAP_IR: ir_sh_ff <= {ir_ff[2], IR_CAPT}; // [R13]
                S_SH_IR:  ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]}; // [R12]
                S_UPD_IR: ir_ff    <= ir_sh_ff;
                default:  ir_sh_ff <= ir_sh_ff;
            endcase
        end
    end
    // undefined codes fall back to bypass, so a slip stays harmless [R6]
    logic sel_bsr;
    logic sel_id;
    assign sel_bsr = (ir_ff == INS_EXTEST) || (ir_ff == INS_SAMPZ)
                  || (ir_ff == INS_SAMPLE); // [R2] [R5] [R7]
    assign sel_id  = (ir_ff == INS_IDCODE); // [R3]
    // ------------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------------
    logic [ID_W-1:0]  id_ff;    // identification shift register
    logic             byp_ff;   // bypass cell
    logic [BSR_W-1:0] bsr_ff;   // boundary shift chain
    logic [BSR_W-1:0] bsu_ff;   // boundary update latches
    logic [ID_W-1:0]  id_word;
    logic [BSR_W-1:0] ring;
    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, ID_PRESENT}; // [R8] [R9] [R10]
    // ring: pins around the internal cell, which reads its own latch
    assign ring = {pin_t_ff[PIN_W-1:BSR_OE], bsu_ff[BSR_OE],
                   pin_t_ff[BSR_OE-1:0]};
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) begin
            id_ff  <= '0;
            byp_ff <= 1'h0;
            bsr_ff <= '0;
        end else if (st_ff == S_CAP_DR) begin
            id_ff  <= id_word; // [R3]
            byp_ff <= 1'h0; // [R11]
            if (sel_bsr) bsr_ff <= ring; // [R2] [R5] [R7] [R15]
        end else if (st_ff == S_SH_DR) begin
            if (sel_id)       id_ff  <= {tdi, id_ff[ID_W-1:1]}; // [R12]
            else if (sel_bsr) bsr_ff <= {tdi, bsr_ff[BSR_W-1:1]}; // msb at tdi
            else              byp_ff <= tdi; // [R11]
        end
    end
    // update latches; the internal cell starts high so outputs drive
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) begin
            bsu_ff         <= '0;
            bsu_ff[BSR_OE] <= 1'h1;
        end else if (st_ff == S_RESET) begin
            bsu_ff[BSR_OE] <= 1'h1;
        end else if (st_ff == S_UPD_DR && sel_bsr) begin
            bsu_ff <= bsr_ff;
        end
    end
    // ------------------------------------------------------------------
    // memory-side controls, straight from flops (tck domain)
    // ------------------------------------------------------------------
    // idcode, sample and bypass leave memory alone [R4] [R7] [R11]
    always_ff @(posedge tck or negedge rt_n) begin
        if (!rt_n) begin
            extest_mode <= 1'h0;
            out_float   <= 1'h0;
            pin_drive   <= '0;
        end else begin
            extest_mode <= (ir_ff == INS_EXTEST);
            out_float   <= (ir_ff == INS_SAMPZ) // [R5]
                        || (ir_ff == INS_EXTEST && !bsu_ff[BSR_OE]);
            pin_drive   <= {bsu_ff[BSR_W-1:BSR_OE+1], bsu_ff[BSR_OE-1:0]};
        end
    end
    // ------------------------------------------------------------------
    // serial output, launched on the falling edge
    // ------------------------------------------------------------------
    logic so;
    always_comb begin
        if (st_ff == S_SH_IR)  so = ir_sh_ff[0];
        else if (sel_id)       so = id_ff[0];
        else if (sel_bsr)      so = bsr_ff[0];
        else                   so = byp_ff;
    end
    always_ff @(negedge tck or negedge rt_n) begin
        if (!rt_n) begin
            tdo    <= 1'h0;
            tdo_oe <= 1'h0;
        end else begin
            tdo    <= so; // [R12]
            tdo_oe <= (st_ff == S_SH_IR) || (st_ff == S_SH_DR);
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_five_ones;
        @(posedge tck) disable iff (!rt_n)
        tms [*5] |=> st_ff == S_RESET;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("no reset after five tms"); // [R1]
    property p_capir;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_CAP_IR |=> ir_sh_ff[1:0] == IR_CAPT;
    endproperty
    a_capir: assert property (p_capir) else $error("capture-ir pattern wrong"); // [R13]
    property p_rst_id;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_RESET |=> ir_ff == INS_IDCODE;
    endproperty
    a_rst_id: assert property (p_rst_id) else $error("reset did not load id"); // [R14]
    property p_idcap;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_CAP_DR |=> id_ff == id_word;
    endproperty
    a_idcap: assert property (p_idcap) else $error("id capture wrong"); // [R3]
    property p_idbit0;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_CAP_DR && sel_id ##1 st_ff == S_SH_DR |-> so == 1'h1;
    endproperty
    a_idbit0: assert property (p_idbit0) else $error("id bit 0 not one"); // [R10]
    property p_float;
        @(posedge tck) disable iff (!rt_n)
        ir_ff == INS_SAMPZ |=> out_float;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated"); // [R5]
    property p_quiet;
        @(posedge tck) disable iff (!rt_n)
        (ir_ff == INS_IDCODE || ir_ff == INS_SAMPLE || ir_ff == INS_BYPASS)
        |=> !out_float && !extest_mode;
    endproperty
    a_quiet: assert property (p_quiet) else $error("memory disturbed"); // [R4] [R7]
    property p_bypass;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_SH_DR && ir_ff == INS_BYPASS && nxt_st == S_SH_DR
        |=> byp_ff == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // [R11]
    property p_bsrcap;
        @(posedge tck) disable iff (!rt_n)
        st_ff == S_CAP_DR && ir_ff == INS_EXTEST |=> bsr_ff == $past(ring);
    endproperty
    a_bsrcap: assert property (p_bsrcap) else $error("ring capture wrong"); // [R2]
endmodule : sram_boundary_scan_tap
`default_nettype wire

// File: rtl/tap_pkg.sv
// constants for the boundary-scan test access port
// assumes a single tck domain for the tap logic, clk_sys for the core side
package tap_pkg;
    // ------------------------------------------------------------------
    // register sizes
    // ------------------------------------------------------------------
    localparam int IR_W    = 3;    // instruction register width
    localparam int ID_W    = 32;   // identification register width
    localparam int BSR_W   = 107;  // boundary scan register length
    localparam int BSR_OE  = 47;   // internal output-enable cell
    localparam int PIN_W   = 106;  // pin cells, all but the internal one
    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam logic [2:0] INS_EXTEST  = 3'h0;  // drive preloaded pins
    localparam logic [2:0] INS_IDCODE  = 3'h1;  // identification
    localparam logic [2:0] INS_SAMPZ   = 3'h2;  // sample, outputs floated
    localparam logic [2:0] INS_SAMPLE  = 3'h4;  // sample / preload
    localparam logic [2:0] INS_BYPASS  = 3'h7;  // single-bit bypass
    localparam logic [1:0] IR_CAPT     = 2'h1;  // capture-ir pattern
    // ------------------------------------------------------------------
    // identification word fields (values arbitrary, not a real part)
    // ------------------------------------------------------------------
    localparam logic [2:0]  ID_VERSION = 3'h2;       // arbitrary
    localparam logic [16:0] ID_PART    = 17'h0A5A5;  // arbitrary
    localparam logic [10:0] ID_MAKER   = 11'h123;    // arbitrary
    localparam logic        ID_PRESENT = 1'h1;       // id register present
    // tap controller states
    typedef enum logic [3:0] {
        S_RESET, S_IDLE, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR,
        S_EX2_DR, S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR,
        S_PAU_IR, S_EX2_IR, S_UPD_IR
    } tap_state_t;
endpackage : tap_pkg

// File: tb/sram_boundary_scan_tap_tb.sv
// self-checking bench for the boundary-scan port
// assumes the tester model owns tck, tms and tdi
`timescale 1ns/1ps
`default_nettype none
module sram_boundary_scan_tap_tb;
    import tap_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic               clk_sys = 1'b0;   // 200 MHz
    logic               rst_n   = 1'b0;   // active low
    logic [PIN_W-1:0]   pin_state = '0;   // ring levels
    wire logic          tck, tms, tdi;    // from tester
    logic               tdo, tdo_oe;      // serial out
    logic [PIN_W-1:0]   pin_drive;        // update latches
    logic               extest_mode;      // 000 active
    logic               out_float;        // outputs high-z
    logic [106:0]       d;                // scan result
    int                 n_fail = 0;       // mismatches
    int                 comparisons = 0;  // checks made
    int                 cycles = 0;       // timeout counter
    int                 oe_rises = 0;     // tck rises seen with tdo_oe high
    // pin and preload patterns, arbitrary
    localparam logic [PIN_W-1:0] P = 106'h2_3456_789A_BCDE_F012_3456_789A;
    localparam logic [PIN_W-1:0] Q = 106'h1_C3A5_0F96_5AC3_E187_7E81_A55A;
    localparam logic [31:0] IDW = {ID_VERSION, ID_PART, ID_MAKER, ID_PRESENT};
    always #2.5 clk_sys = ~clk_sys;
    // ------------------------------------------------------------------
    // design and tester
    // ------------------------------------------------------------------
    sram_boundary_scan_tap i_sram_boundary_scan_tap (
        .clk_sys(clk_sys), .rst_n(rst_n), .pin_state(pin_state),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .pin_drive(pin_drive), .extest_mode(extest_mode), .out_float(out_float));
    tap_tester i_tap_tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    // ------------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [106:0] got, input logic [106:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    // expected boundary chain image with internal cell at 47
    function automatic logic [106:0] chain(input logic [PIN_W-1:0] p, input logic c);
        return {p[105:47], c, p[46:0]};
    endfunction : chain
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // shift enable watch: one count per shifting rise
    always @(posedge tck) begin
        if (tdo_oe) oe_rises++;
    end
    // hang guard, tests need about 15k cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        i_tap_tester.tms_reset();
        i_tap_tester.scan(1'b0, 32, '0, d);
        check(d[31:0], IDW, "id word");
        check({extest_mode, out_float}, 2'h0, "id quiet");
        check(oe_rises[7:0], 8'h20, "shift enable");
        $display("test identification done");
        i_tap_tester.scan(1'b1, 3, INS_BYPASS, d);
        check(d[2:0], 3'h1, "capture-ir");
        i_tap_tester.scan(1'b0, 2, 2'h1, d);
        check(d[1:0], 2'h2, "bypass path");
        $display("test bypass done");
        @(negedge clk_sys);
        pin_state = P;
        i_tap_tester.idle(4);
        i_tap_tester.scan(1'b1, 3, INS_SAMPLE, d);
        check(d[2:0], 3'h5, "capture-ir hi");
        i_tap_tester.scan(1'b0, 107, chain(Q, 1'b1), d);
        check({d[106:48], d[46:0]}, P, "sample pins");
        check(d[47], 1'b1, "internal cell");
        check({extest_mode, out_float}, 2'h0, "sample quiet");
        $display("test sample done");
        i_tap_tester.scan(1'b1, 3, INS_SAMPZ, d);
        // controls follow the new instruction one tck rise later
        i_tap_tester.idle(1);
        check(out_float, 1'b1, "sampz float");
        i_tap_tester.scan(1'b0, 107, chain(Q, 1'b1), d);
        check({d[106:48], d[46:0]}, P, "sampz pins");
        $display("test sample-z done");
        i_tap_tester.scan(1'b1, 3, INS_EXTEST, d);
        i_tap_tester.idle(1);
        check({extest_mode, out_float}, 2'h2, "extest on");
        check(pin_drive, Q, "preload drive");
        i_tap_tester.scan(1'b0, 107, chain(Q, 1'b0), d);
        check({d[106:48], d[46:0]}, P, "extest ring");
        // latched cell reaches out_float on the next rise
        i_tap_tester.idle(1);
        check(out_float, 1'b1, "cell 47 float");
        $display("test extest done");
        i_tap_tester.tms_reset();
        check({extest_mode, out_float}, 2'h0, "reset clears");
        i_tap_tester.scan(1'b0, 32, '0, d);
        check(d[31:0], IDW, "id after reset");
        $display("test tms reset done");
        report_and_stop();
    end
endmodule : sram_boundary_scan_tap_tb
`default_nettype wire

// File: tb/tap_tester.sv
// external boundary-scan tester model that drives the test port
// assumes the tap rests in run-test/idle between scans
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
    // test port
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // clock rests low outside frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // ------------------------------------------------------------------
    // one tck period of 160 ns
    // ------------------------------------------------------------------
    task automatic bit_cyc(input logic m, input logic d, output logic q);
        tms = m;  // set up well before the rise
        tdi = d;
        #80;
        q = tdo;  // launched by the device on the last fall
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask : bit_cyc
    // tms high five rises, then park in idle
    task automatic tms_reset();
        logic q;
        repeat (5) bit_cyc(1'b1, 1'b0, q);
        bit_cyc(1'b0, 1'b0, q);
    endtask : tms_reset
    // idle cycles; tdi toggles since nobody reads it here
    task automatic idle(input int n);
        logic q;
        repeat (n) bit_cyc(1'b0, ~tdi, q);
    endtask : idle
    // ------------------------------------------------------------------
    // full ir or dr scan from idle back to idle, lsb first
    // ------------------------------------------------------------------
    task automatic scan(input logic ir, input int n, input logic [106:0] din,
                        output logic [106:0] dout);
        logic q;
        dout = '0;
        bit_cyc(1'b1, 1'b0, q);           // select-dr
        if (ir) bit_cyc(1'b1, 1'b0, q);   // select-ir
        bit_cyc(1'b0, 1'b0, q);           // capture
        bit_cyc(1'b0, 1'b0, q);           // into shift
        for (int i = 0; i < n; i++) begin
            bit_cyc(i == n - 1, din[i], q);  // last bit moves to exit1
            dout[i] = q;
        end
        bit_cyc(1'b1, 1'b0, q);           // update
        bit_cyc(1'b0, 1'b0, q);           // idle
    endtask : scan
endmodule : tap_tester
`default_nettype wire
